/* File: rtcc_calendar_trim.sv */
/*
 * Calendar counters, time trim register and weekly alarm time registers.
 * Assumes the serial host port delivers one-cycle register requests on clk,
 * that osc_halt_flag and day_carry come from logic on clk, and that osc_in is
 * the raw 32.768 kHz oscillator level from outside the clock domain.
 * SEC_LEN keeps its default in silicon; only a bench shortens it.
 */
module rtcc_calendar_trim
  import rtcc_pkg::*;
#(
  // Oscillator ticks in an untrimmed second; the trim offsets do not depend on it.
  parameter logic [16:0] SEC_LEN = `RTCC_NOMINAL_LEN
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc_in,
  input wire logic osc_halt_flag,
  input wire logic day_carry,
  input wire logic [7:0] sec_bcd,
  input wire rtcc_reg_req_type reg_req,
  output logic [7:0] reg_rd_data,
  output logic second_pulse,
  output logic leap_year
);

  // ****************************************************************************
  // Decoding functions
  // ****************************************************************************

  // Adds one to a two-digit BCD value.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction : bcd_inc

  // Tells whether a BCD year is a multiple of four.
  function automatic logic is_leap(input logic [7:0] y);
    logic [1:0] m;
    m = 2'({y[4], 1'b0} + y[1:0]);
    return m == 2'h0;
  endfunction : is_leap

  // Gives the last BCD day of a BCD month.
  function automatic logic [7:0] last_day(input logic [4:0] mon, input logic leap);
    logic [7:0] d;
    d = 8'h31;
    unique case (mon)
      5'h04, 5'h06, 5'h09, 5'h11: d = 8'h30;
      5'h02: d = leap ? 8'h29 : 8'h28;
      default: d = 8'h31;
    endcase
    return d;
  endfunction : last_day

  // Tells whether a request writes the register at the given offset.
  function automatic logic wr_hit(input rtcc_reg_req_type rq, input logic [3:0] ofs);
    return rq.wr && (rq.addr == ofs);
  endfunction : wr_hit

  // ****************************************************************************
  // Oscillator synchroniser and halt edge
  // ****************************************************************************

  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic halt_prev;
  logic osc_tick;
  logic halt_rise;
  logic next_osc_meta;
  logic next_osc_sync;
  logic next_osc_prev;
  logic next_halt_prev;

  // Next values of the synchroniser chain and of the halt edge memory.
  always_comb begin
    next_osc_meta = osc_in;
    next_osc_sync = osc_meta;
    next_osc_prev = osc_sync;
    next_halt_prev = osc_halt_flag;
  end

  // Two flops bring the oscillator in; a third finds its rising edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      halt_prev <= 1'b0;
    end else begin
      osc_meta <= next_osc_meta;
      osc_sync <= next_osc_sync;
      osc_prev <= next_osc_prev;
      halt_prev <= next_halt_prev;
    end
  end

  // Edge pulses for the divider and the trim clear.
  assign osc_tick = osc_sync && !osc_prev;
  assign halt_rise = osc_halt_flag && !halt_prev;

  // ****************************************************************************
  // Register state
  // ****************************************************************************

  logic [7:0] day;
  logic [4:0] month;
  logic century;
  logic [7:0] year;
  logic [6:0] trim_value;
  logic trim_enable;
  logic [6:0] alarm_min;
  logic [5:0] alarm_hour;
  logic [7:0] next_day;
  logic [4:0] next_month;
  logic next_century;
  logic [7:0] next_year;
  logic [6:0] next_trim_value;
  logic next_trim_enable;
  logic [6:0] next_alarm_min;
  logic [5:0] next_alarm_hour;
  logic [7:0] next_reg_rd_data;
  logic next_leap_year;
  logic trim_write;
  logic wr_day;
  logic wr_month;
  logic wr_year;
  logic wr_wmin;
  logic wr_whour;

  // Write strobes per register; trim takes only writes with bit 7 clear.
  always_comb begin
    wr_day = wr_hit(reg_req, `RTCC_OFS_DAY);
    wr_month = wr_hit(reg_req, `RTCC_OFS_MONTH);
    wr_year = wr_hit(reg_req, `RTCC_OFS_YEAR);
    wr_wmin = wr_hit(reg_req, `RTCC_OFS_WMIN);
    wr_whour = wr_hit(reg_req, `RTCC_OFS_WHOUR);
    trim_write = wr_hit(reg_req, `RTCC_OFS_TRIM) &&
                 !reg_req.data[`RTCC_BIT_TRIM_LOCK];
  end

  // ****************************************************************************
  // Calendar counting
  // ****************************************************************************

  // Advances day, month, year and century; a host write wins over a count.
  always_comb begin
    next_day = day;
    next_month = month;
    next_century = century;
    next_year = year;
    if (day_carry) begin
      if (day == last_day(month, is_leap(year))) begin
        next_day = `RTCC_FIRST_DAY;
        if (month == `RTCC_LAST_MONTH) begin
          next_month = `RTCC_FIRST_MONTH;
          if (year == `RTCC_LAST_YEAR) begin
            next_year = `RTCC_FIRST_YEAR;
            next_century = !century;
          end else begin
            next_year = bcd_inc(year);
          end
        end else begin
          next_month = 5'(bcd_inc({3'h0, month}));
        end
      end else begin
        next_day = bcd_inc(day);
      end
    end
    if (wr_day) begin
      next_day = reg_req.data & `RTCC_MASK_DAY;
    end
    if (wr_month) begin
      next_month = reg_req.data[4:0];
      next_century = reg_req.data[`RTCC_BIT_CENTURY];
    end
    if (wr_year) begin
      next_year = reg_req.data;
    end
  end

  // ****************************************************************************
  // Trim and alarm registers
  // ****************************************************************************

  // Trim write enables trimming; a halt rising clears it and wins.
  always_comb begin
    next_trim_value = trim_value;
    next_trim_enable = trim_enable;
    next_alarm_min = alarm_min;
    next_alarm_hour = alarm_hour;
    if (trim_write) begin
      next_trim_value = 7'(reg_req.data & `RTCC_MASK_TRIM);
      next_trim_enable = 1'b1;
    end
    if (halt_rise) begin
      next_trim_value = `RTCC_RST_TRIM;
      next_trim_enable = 1'b0;
    end
    if (wr_wmin) begin
      next_alarm_min = 7'(reg_req.data & `RTCC_MASK_WMIN);
    end
    if (wr_whour) begin
      next_alarm_hour = 6'(reg_req.data & `RTCC_MASK_WHOUR);
    end
  end

  // ****************************************************************************
  // Read port
  // ****************************************************************************

  // Read data is registered; fixed-zero bits and unmapped offsets read zero.
  always_comb begin
    next_reg_rd_data = reg_rd_data;
    next_leap_year = is_leap(next_year);
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `RTCC_OFS_DAY: next_reg_rd_data = day & `RTCC_MASK_DAY;
        `RTCC_OFS_MONTH: next_reg_rd_data = {century, 2'h0, month};
        `RTCC_OFS_YEAR: next_reg_rd_data = year;
        `RTCC_OFS_TRIM: next_reg_rd_data = {1'b0, trim_value};
        `RTCC_OFS_WMIN: next_reg_rd_data = {1'b0, alarm_min};
        `RTCC_OFS_WHOUR: next_reg_rd_data = {2'h0, alarm_hour};
        default: next_reg_rd_data = `RTCC_READ_ZERO;
      endcase
    end
  end

  // Registers all register-file and calendar state.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      day <= `RTCC_RST_DAY;
      month <= `RTCC_FIRST_MONTH;
      century <= 1'b0;
      year <= `RTCC_RST_YEAR;
      trim_value <= `RTCC_RST_TRIM;
      trim_enable <= 1'b0;
      alarm_min <= 7'(`RTCC_RST_ALARM);
      alarm_hour <= 6'(`RTCC_RST_ALARM);
      reg_rd_data <= `RTCC_READ_ZERO;
      leap_year <= 1'b1;
    end else begin
      day <= next_day;
      month <= next_month;
      century <= next_century;
      year <= next_year;
      trim_value <= next_trim_value;
      trim_enable <= next_trim_enable;
      alarm_min <= next_alarm_min;
      alarm_hour <= next_alarm_hour;
      reg_rd_data <= next_reg_rd_data;
      leap_year <= next_leap_year;
    end
  end

  // ****************************************************************************
  // Second divider
  // ****************************************************************************

  rtcc_trim_type trim_cfg;

  // Hands the live trim setting to the divider.
  assign trim_cfg = '{enable: trim_enable, value: trim_value};

  rtcc_second_divider #(.SEC_LEN(SEC_LEN)) u_divider (
    .clk(clk),
    .rstn(rstn),
    .osc_tick(osc_tick),
    .trim(trim_cfg),
    .trim_write(trim_write),
    .sec_bcd(sec_bcd),
    .second_pulse(second_pulse)
  );

endmodule : rtcc_calendar_trim

/* File: rtcc_consts.svh */
/*
 * Constants of the calendar, trim and weekly alarm block: register offsets,
 * field masks, reset values and second-length figures.
 * Assumes it is included by bare name from the package.
 */
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define RTCC_OFS_DAY 4'h4
`define RTCC_OFS_MONTH 4'h5
`define RTCC_OFS_YEAR 4'h6
`define RTCC_OFS_TRIM 4'h7
`define RTCC_OFS_WMIN 4'h8
`define RTCC_OFS_WHOUR 4'h9

// ****************************************************************************
// Field masks of writable and readable bits
// ****************************************************************************
`define RTCC_MASK_DAY 8'h3F
`define RTCC_MASK_MONTH 8'h9F
`define RTCC_MASK_WMIN 8'h7F
`define RTCC_MASK_WHOUR 8'h3F
`define RTCC_MASK_TRIM 8'h7F
`define RTCC_BIT_CENTURY 7
`define RTCC_BIT_TRIM_LOCK 7
`define RTCC_BIT_TRIM_DIR 6

// ****************************************************************************
// Reset values and calendar figures
// ****************************************************************************
`define RTCC_RST_DAY 8'h01
`define RTCC_RST_MONTH 8'h01
`define RTCC_RST_YEAR 8'h00
`define RTCC_RST_TRIM 7'h00
`define RTCC_RST_ALARM 8'h00
`define RTCC_FIRST_DAY 8'h01
`define RTCC_FIRST_MONTH 5'h01
`define RTCC_LAST_MONTH 5'h12
`define RTCC_LAST_YEAR 8'h99
`define RTCC_FIRST_YEAR 8'h00
`define RTCC_READ_ZERO 8'h00

// ****************************************************************************
// Second length and trim points
// ****************************************************************************
`define RTCC_NOMINAL_LEN 17'h08000
`define RTCC_TRIM_BIAS 17'h00002
`define RTCC_SEC_POINT_A 8'h00
`define RTCC_SEC_POINT_B 8'h20
`define RTCC_SEC_POINT_C 8'h40

`endif

/* File: rtcc_pkg.sv */
/*
 * Types shared by the calendar, trim and weekly alarm block.
 * Assumes rtcc_consts.svh is on the include path.
 */
`include "rtcc_consts.svh"

package rtcc_pkg;

  // Register access request from the serial host port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] data;
  } rtcc_reg_req_type;

  // Trim setting handed to the second divider.
  typedef struct packed {
    logic enable;
    logic [6:0] value;
  } rtcc_trim_type;

endpackage : rtcc_pkg

/* File: rtcc_second_divider.sv */
/*
 * Second divider: counts oscillator ticks and emits one pulse per second,
 * lengthening or shortening the second at the 00, 20 and 40 second points.
 * Assumes osc_tick is a one-cycle pulse already synchronised to clk, and that
 * sec_bcd is updated by the time counter well before the next oscillator tick.
 */
module rtcc_second_divider
  import rtcc_pkg::*;
#(
  parameter logic [16:0] SEC_LEN = `RTCC_NOMINAL_LEN
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc_tick,
  input wire rtcc_trim_type trim,
  input wire logic trim_write,
  input wire logic [7:0] sec_bcd,
  output logic second_pulse
);

  logic [16:0] cnt;
  logic skip;
  logic [16:0] next_cnt;
  logic next_skip;
  logic next_second_pulse;
  logic sec_point;
  logic [16:0] len;
  logic [16:0] mag2;

  // ****************************************************************************
  // Length of the current second
  // ****************************************************************************

  // Works out the second length from the trim value and the seconds point.
  always_comb begin
    sec_point = (sec_bcd == `RTCC_SEC_POINT_A) || (sec_bcd == `RTCC_SEC_POINT_B) ||
                (sec_bcd == `RTCC_SEC_POINT_C);
    len = SEC_LEN;
    mag2 = '0;
    if (trim.enable && sec_point && !skip && (trim.value[5:0] != 6'h00)) begin
      if (!trim.value[`RTCC_BIT_TRIM_DIR]) begin
        mag2 = {10'h000, trim.value[5:0], 1'b0};
        len = 17'(SEC_LEN + mag2 - `RTCC_TRIM_BIAS);
      end else begin
        mag2 = {10'h000, ~trim.value[5:0], 1'b0};
        len = 17'(SEC_LEN - mag2 - `RTCC_TRIM_BIAS);
      end
    end
  end

  // ****************************************************************************
  // Tick counter
  // ****************************************************************************

  // Counts ticks; a trim write inside a trim point cancels that correction.
  always_comb begin
    next_cnt = cnt;
    next_skip = skip;
    next_second_pulse = 1'b0;
    if (trim_write) begin
      next_skip = 1'b1;
    end
    if (osc_tick) begin
      if (cnt >= 17'(len - 17'h00001)) begin
        next_cnt = '0;
        next_second_pulse = 1'b1;
        next_skip = trim_write;
      end else begin
        next_cnt = 17'(cnt + 17'h00001);
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
      skip <= 1'b0;
      second_pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      skip <= next_skip;
      second_pulse <= next_second_pulse;
    end
  end

endmodule : rtcc_second_divider

/* File: rtcc_calendar_trim_checker.sv */
/*
 * Port checker of the calendar, trim and weekly alarm block.
 * Assumes rtcc_pkg is compiled first and one clock domain on clk.
 */
module rtcc_calendar_trim_checker
  import rtcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc_halt_flag,
  input wire rtcc_reg_req_type reg_req,
  input wire logic [7:0] reg_rd_data,
  input wire logic second_pulse
);
  // ********
  // Sequences
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // A halt edge, a quiet cycle, then a plain read of the trim register.
  sequence s_halt_read;
    $rose(osc_halt_flag) ##1 !reg_req.wr ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == 4'h7);
  endsequence

  // A write of the alarm minute, an idle cycle, then its read.
  sequence s_wmin_back;
    (reg_req.wr && !reg_req.rd && reg_req.addr == 4'h8) ##1 !reg_req.wr ##1
      (reg_req.rd && !reg_req.wr && reg_req.addr == 4'h8);
  endsequence

  // ********
  // Assertions
  // ********
  AST_DAY_TOP: assert property (reg_req.rd && reg_req.addr == 4'h4 |=> reg_rd_data[7:6] == 2'h0)
    else $error("day register top bits not zero");
  AST_MONTH_GAP: assert property (reg_req.rd && reg_req.addr == 4'h5 |=> reg_rd_data[6:5] == 2'h0)
    else $error("month register middle bits not zero");
  AST_TRIM_TOP: assert property (reg_req.rd && reg_req.addr == 4'h7 |=> !reg_rd_data[7])
    else $error("trim register top bit not zero");
  AST_WMIN_TOP: assert property (reg_req.rd && reg_req.addr == 4'h8 |=> !reg_rd_data[7])
    else $error("alarm minute top bit not zero");
  AST_WHOUR_TOP: assert property (reg_req.rd && reg_req.addr == 4'h9 |=> reg_rd_data[7:6] == 2'h0)
    else $error("alarm hour top bits not zero");
  AST_UNMAPPED: assert property (reg_req.rd && (reg_req.addr < 4'h4 || reg_req.addr > 4'h9)
    |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!reg_req.rd |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
  AST_HALT_CLR: assert property (s_halt_read |=> reg_rd_data == 8'h00)
    else $error("trim not cleared by halt");
  AST_WMIN_BACK: assert property (s_wmin_back |=> reg_rd_data == ($past(reg_req.data, 3) & 8'h7F))
    else $error("alarm minute read back wrong");
  AST_PULSE_GAP: assert property (second_pulse |=> !second_pulse [*8])
    else $error("second pulse too long");
endmodule : rtcc_calendar_trim_checker

bind rtcc_calendar_trim rtcc_calendar_trim_checker rtcc_calendar_trim_checker_i (.clk(clk), .rstn(rstn),
  .osc_halt_flag(osc_halt_flag), .reg_req(reg_req), .reg_rd_data(reg_rd_data), .second_pulse(second_pulse));

/* File: rtcc_testbench.sv */
/*
 * Self-checking testbench of the calendar, trim and weekly alarm block.
 * Assumes the package, design and checker files are compiled before it.
 */
module testbench
  import rtcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC_TICKS = 256;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic osc_in = 1'b0;
  logic osc_halt_flag = 1'b0;
  logic day_carry = 1'b0;
  logic [7:0] sec_bcd = 8'h00;
  rtcc_reg_req_type req = '0;
  logic [7:0] reg_rd_data;
  logic second_pulse;
  logic leap_year;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int ph = 0;
  int span;
  int mreg [16];
  int msk [16] = '{4: 32'h3F, 5: 32'h9F, 6: 32'hFF, 7: 32'h7F, 8: 32'h7F, 9: 32'h3F, default: 0};
  int yrs [4] = '{32'h23, 32'h24, 32'h00, 32'h99};

  // A short second keeps the run brief; the trim offsets are the same at any length.
  rtcc_calendar_trim #(.SEC_LEN(17'(SEC_TICKS))) rtcc_calendar_trim_i (.clk(clk), .rstn(rstn), .osc_in(osc_in),
    .osc_halt_flag(osc_halt_flag), .day_carry(day_carry), .sec_bcd(sec_bcd), .reg_req(req),
    .reg_rd_data(reg_rd_data), .second_pulse(second_pulse), .leap_year(leap_year));

  // ********
  // Clock, oscillator and time limit
  // ********
  // The oscillator ticks every third cycle; the edge detector would also take a tick every second cycle.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    ph <= (ph + 1) % 3;
    osc_in <= (ph != 2);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end

  // ********
  // Model and tasks
  // ********
  function automatic int b2i(input int b);
    return b / 16 * 10 + b % 16;
  endfunction : b2i
  function automatic int i2b(input int i);
    return i / 10 * 16 + i % 10;
  endfunction : i2b
  function automatic int last_day(input int mo, input int y);
    if (mo == 2) begin
      return (y % 4 == 0) ? 29 : 28;
    end
    return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
  endfunction : last_day

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask : chk

  // One register access: request for one edge, then one idle edge.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    req <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    if (!(a == 4'h7 && d[7])) begin
      mreg[a] = d & msk[a];
    end
  endtask : wr
  task automatic rd(input logic [3:0] a);
    acc(1'b0, a, 8'h00);
    chk("read data", reg_rd_data, mreg[a]);
  endtask : rd
  // Cycles from one second pulse to the next, with an optional trim write at the start.
  task automatic sec_len(output int n, input logic w, input logic [7:0] d);
    while (second_pulse !== 1'b1) @(posedge clk);
    n = 0;
    if (w) begin
      wr(4'h7, d);
      n = 2;
    end
    do begin
      n++;
      @(posedge clk);
    end while (second_pulse !== 1'b1);
  endtask : sec_len
  task automatic carry();
    int d, mo, y;
    day_carry <= 1'b1;
    @(posedge clk);
    day_carry <= 1'b0;
    @(posedge clk);
    d = b2i(mreg[4]);
    mo = b2i(mreg[5] & 32'h1F);
    y = b2i(mreg[6]);
    if (d == last_day(mo, y)) begin
      d = 1;
      if (mo == 12) begin
        mo = 1;
        y = (y + 1) % 100;
        mreg[5] = (y == 0) ? mreg[5] ^ 32'h80 : mreg[5];
      end else begin
        mo++;
      end
    end else begin
      d++;
    end
    mreg[4] = i2b(d);
    mreg[5] = (mreg[5] & 32'h80) | i2b(mo);
    mreg[6] = i2b(y);
    chk("leap flag", leap_year, y % 4 == 0);
  endtask : carry

  task automatic wrap_up();
    $display("checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(32'h24F9));
    mreg = '{default: 0};
    mreg[4] = 1;
    mreg[5] = 1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a++) rd(a[3:0]);
    wr(4'h7, 8'h87);
    rd(4'h7);
    wr(4'h7, 8'h07);
    rd(4'h7);
    repeat (4) begin
      wr(4'h8, 8'($urandom));
      rd(4'h8);
      wr(4'h9, 8'($urandom));
      rd(4'h9);
    end
    foreach (yrs[i]) begin
      for (int mo = 1; mo <= 12; mo++) begin
        wr(4'h6, 8'(yrs[i]));
        wr(4'h5, 8'(i2b(mo) | ($urandom & 32'h80)));
        wr(4'h4, 8'(i2b(last_day(mo, b2i(yrs[i])) - 1)));
        repeat (2) begin
          carry();
          for (int a = 4; a <= 6; a++) rd(a[3:0]);
        end
      end
    end
    // Seconds are timed pulse to pulse; each oscillator tick takes three clock cycles.
    sec_len(span, 1'b0, 8'h00);
    chk("second length", span, 3 * (SEC_TICKS + 2 * (7 - 1)));
    sec_bcd <= 8'h20;
    sec_len(span, 1'b1, 8'h7E);
    chk("second length", span, 3 * SEC_TICKS);
    sec_len(span, 1'b0, 8'h00);
    chk("second length", span, 3 * (SEC_TICKS - 2 * (1 + 1)));
    sec_bcd <= 8'h01;
    sec_len(span, 1'b0, 8'h00);
    chk("second length", span, 3 * SEC_TICKS);
    sec_bcd <= 8'h40;
    sec_len(span, 1'b1, 8'h40);
    chk("second length", span, 3 * SEC_TICKS);
    sec_len(span, 1'b0, 8'h00);
    chk("second length", span, 3 * SEC_TICKS);
    osc_halt_flag <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    mreg[7] = 0;
    rd(4'h7);
    wr(4'h7, 8'h15);
    rd(4'h7);
    osc_halt_flag <= 1'b0;
    wrap_up();
  end
endmodule : testbench
